// File: rtl/csm_pkg.sv
// constants and types for the core state and mode control block
// assumes a single 40 MHz clock domain and no software-visible registers
//
// Contract
// [RULE1] branch-exchange with operand bit 0 set enters the compact state
// [RULE2] exception return restores the compact state if it was saved
// [RULE3] branch-exchange with operand bit 0 clear enters the wide state
// [RULE4] exception entry forces wide state, saves pc to link, jumps to vector
// [RULE5] changing instruction state keeps the mode and all registers
// [RULE6] wide state fetches aligned words, compact state halfwords by pc bit 1
// [RULE7] byte addressing, little-endian words, lowest byte at lowest address
// [RULE8] byte, halfword and word data; words and halfwords naturally aligned
// [RULE9] exactly six modes: user, fast irq, irq, supervisor, system, undefined
// [RULE10] mode changes by software or exception; exceptions enter privileged modes
// [RULE11] 34 registers: 29 general 32-bit plus five status registers
// [RULE12] no registers are provided for an abort mode
// [RULE13] pc reads with bits 1:0 zero in wide, bit 0 zero in compact
// [RULE14] fast irq mode banks seven registers in place of r8 to r14
// [RULE15] fixed five-bit mode encoding used in the status mode field
package csm_pkg;
	localparam int CSM_XLEN     = 32;
	localparam int CSM_NGPR     = 29;
	localparam int CSM_NPSR     = 5;
	localparam int CSM_PSR_T    = 5;
	localparam int CSM_LR_IDX   = 14;
	localparam int CSM_SP_IDX   = 13;
	localparam int CSM_PC_IDX   = 15;
	localparam logic [31:0] CSM_RESET_PC  = 32'h0000_0000;
	localparam logic [31:0] CSM_RESET_PSR = 32'h0000_00d3;

	// mode field encoding
	localparam logic [4:0] CSM_M_USR = 5'h10; // RULE15
	localparam logic [4:0] CSM_M_FIQ = 5'h11;
	localparam logic [4:0] CSM_M_IRQ = 5'h12;
	localparam logic [4:0] CSM_M_SVC = 5'h13;
	localparam logic [4:0] CSM_M_UND = 5'h1b;
	localparam logic [4:0] CSM_M_SYS = 5'h1f;

	// exception kinds
	typedef enum logic [2:0] {
		CSM_EX_RESET,
		CSM_EX_UNDEFINED_INSTR_EXCEPTION,
		CSM_EX_SWI,
		CSM_EX_IRQ,
		CSM_EX_FIQ
	} csm_exc_t;

	localparam logic [31:0] CSM_VEC_RESET = 32'h0000_0000;
	localparam logic [31:0] CSM_VEC_UNDEFINED_INSTR_EXCEPTION = 32'h0000_0004;
	localparam logic [31:0] CSM_VEC_SWI   = 32'h0000_0008;
	localparam logic [31:0] CSM_VEC_IRQ   = 32'h0000_0018;
	localparam logic [31:0] CSM_VEC_FIQ   = 32'h0000_001c;

	// data sizes on the bus
	typedef enum logic [1:0] {
		CSM_SZ_BYTE,
		CSM_SZ_HALF,
		CSM_SZ_WORD
	} csm_size_t;

	typedef enum logic {
		CSM_ST_WIDE,
		CSM_ST_COMPACT
	} csm_istate_t;
endpackage

// File: rtl/csm_bank_map.sv
// maps a visible register number to a physical storage slot
// assumes the mode field is one of the six legal encodings
`timescale 1ns/1ps
`default_nettype none
module csm_bank_map
	import csm_pkg::*;
(
	// selection
	input  wire logic [4:0] mode,
	input  wire logic [3:0] reg_num,
	// result
	output logic      [4:0] slot
);
	// slots 0..15 user set, 16..22 fast irq r8..r14, then r13/r14 pairs
	wire is_fiq  = (mode == CSM_M_FIQ);
	wire is_hi   = (reg_num >= 4'h8) && (reg_num <= 4'he);
	wire is_sl   = (reg_num == 4'hd) || (reg_num == 4'he);
	wire [4:0] pair_base = (mode == CSM_M_SVC) ? 5'h17 :
		(mode == CSM_M_IRQ) ? 5'h19 :
		(mode == CSM_M_UND) ? 5'h1b : 5'h00;
	wire [4:0] rn5  = {1'b0, reg_num};
	wire [4:0] fslot = 5'h10 + (rn5 - 5'h08);
	wire [4:0] pslot = pair_base + {4'h0, reg_num[0] ^ 1'b1};
	// fast irq banks seven, privileged modes bank two, user and system none
	assign slot = (is_fiq && is_hi) ? fslot : // RULE14
		(is_sl && (pair_base != 5'h00)) ? pslot : rn5;
endmodule
`default_nettype wire

// File: rtl/csm_lane.sv
// little-endian byte lane placement for stores and extraction for loads
// assumes addresses already aligned by the caller
`timescale 1ns/1ps
`default_nettype none
module csm_lane
	import csm_pkg::*;
(
	// access
	input  wire logic [1:0]  addr_lo,
	input  wire logic [1:0]  size,
	input  wire logic [31:0] wdata,
	input  wire logic [31:0] bus_rdata,
	// lanes
	output logic      [31:0] bus_wdata,
	output logic      [3:0]  byte_en,
	output logic      [31:0] rdata
);
	// lowest address carries least significant byte
	wire [4:0] sh = {addr_lo, 3'h0}; // RULE7
	wire [3:0] be_b = 4'h1 << addr_lo;
	wire [3:0] be_h = addr_lo[1] ? 4'hc : 4'h3;
	wire [31:0] rsh = bus_rdata >> sh;
	assign byte_en = (size == 2'(CSM_SZ_BYTE)) ? be_b : // RULE8
		(size == 2'(CSM_SZ_HALF)) ? be_h : 4'hf;
	assign bus_wdata = (size == 2'(CSM_SZ_BYTE)) ? {4{wdata[7:0]}} :
		(size == 2'(CSM_SZ_HALF)) ? {2{wdata[15:0]}} : wdata;
	assign rdata = (size == 2'(CSM_SZ_BYTE)) ? {24'h0, rsh[7:0]} :
		(size == 2'(CSM_SZ_HALF)) ? {16'h0, rsh[15:0]} : bus_rdata;
endmodule
`default_nettype wire

// File: rtl/csm_ctrl.sv
// state and mode control: instruction state, mode, banked register file
// assumes the decoder gives one-cycle pulses from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module csm_ctrl
	import csm_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	// control events
	input  wire logic        branch_exchange_instr,
	input  wire logic [3:0]  bx_reg,
	input  wire logic        exc_take,
	input  wire logic [2:0]  exc_kind,
	input  wire logic        exc_return,
	input  wire logic        mode_write,
	input  wire logic [4:0]  mode_wdata,
	input  wire logic        pc_advance,
	// register write port
	input  wire logic        rf_we,
	input  wire logic [3:0]  rf_waddr,
	input  wire logic [31:0] rf_wdata,
	// register read port
	input  wire logic [3:0]  rf_raddr,
	output logic      [31:0] rf_rdata,
	// data access
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	input  wire logic [1:0]  mem_size,
	input  wire logic [31:0] mem_wdata,
	input  wire logic [31:0] bus_rdata,
	output logic      [31:0] mem_rdata,
	output logic      [31:0] bus_wdata,
	output logic      [3:0]  bus_byte_en,
	output logic             mem_misaligned,
	// status
	output logic             compact_state,
	output logic      [4:0]  cur_mode,
	output logic      [31:0] status_word,
	output logic      [31:0] fetch_addr,
	output logic      [1:0]  fetch_size,
	output logic      [31:0] program_counter_reg
);
	localparam int NSLOT = CSM_NGPR;

	// storage: 29 general slots plus one current and four saved status
	logic [31:0] gpr [NSLOT]; // RULE11
	logic [31:0] pc;
	logic [31:0] cpsr;
	logic [31:0] spsr [4]; // RULE12

	initial
	begin
		assert (NSLOT == 29 && CSM_NPSR == 5)
		else $error("register count mismatch");
	end

	// saved status index per exception mode
	function automatic logic [1:0] spsr_idx(input logic [4:0] m);
		unique case (m)
			CSM_M_FIQ: spsr_idx = 2'd0;
			CSM_M_IRQ: spsr_idx = 2'd1;
			CSM_M_SVC: spsr_idx = 2'd2;
			default:   spsr_idx = 2'd3;
		endcase
	endfunction

	// only the six legal encodings are accepted
	function automatic logic mode_ok(input logic [4:0] m);
		mode_ok = (m == CSM_M_USR) || (m == CSM_M_FIQ) || (m == CSM_M_IRQ) ||
			(m == CSM_M_SVC) || (m == CSM_M_UND) || (m == CSM_M_SYS); // RULE9
	endfunction

	// target mode and vector of the exception being taken
	logic [4:0]  exc_mode;
	logic [31:0] exc_vec;
	always_comb
	begin
		exc_mode = CSM_M_SVC;
		exc_vec  = CSM_VEC_RESET;
		unique case (csm_exc_t'(exc_kind))
			CSM_EX_RESET: begin exc_mode = CSM_M_SVC; exc_vec = CSM_VEC_RESET; end
			CSM_EX_UNDEFINED_INSTR_EXCEPTION: begin exc_mode = CSM_M_UND; exc_vec = CSM_VEC_UNDEFINED_INSTR_EXCEPTION; end
			CSM_EX_SWI:   begin exc_mode = CSM_M_SVC; exc_vec = CSM_VEC_SWI;   end
			CSM_EX_IRQ:   begin exc_mode = CSM_M_IRQ; exc_vec = CSM_VEC_IRQ;   end
			CSM_EX_FIQ:   begin exc_mode = CSM_M_FIQ; exc_vec = CSM_VEC_FIQ;   end
			default:      begin exc_mode = CSM_M_SVC; exc_vec = CSM_VEC_RESET; end
		endcase
	end

	wire [4:0] mode = cpsr[4:0];
	wire       tbit = cpsr[CSM_PSR_T];
	wire       can_ret = (mode != CSM_M_USR) && (mode != CSM_M_SYS);
	wire [31:0] saved = spsr[spsr_idx(mode)];

	// banked slot lookup for read, write, operand and exception link
	wire [4:0] rslot;
	wire [4:0] wslot;
	wire [4:0] bslot;
	wire [4:0] lslot;
	csm_bank_map u_rmap (.mode(mode), .reg_num(rf_raddr), .slot(rslot));
	csm_bank_map u_wmap (.mode(mode), .reg_num(rf_waddr), .slot(wslot));
	csm_bank_map u_bmap (.mode(mode), .reg_num(bx_reg), .slot(bslot));
	csm_bank_map u_lmap (.mode(exc_mode), .reg_num(4'(CSM_LR_IDX)), .slot(lslot));

	wire [31:0] bx_op = (bx_reg == 4'(CSM_PC_IDX)) ? pc : gpr[bslot];

	// pc as visible: low bits forced by state
	wire [31:0] pc_vis = tbit ? {pc[31:1], 1'b0} : {pc[31:2], 2'b00}; // RULE13

	// event priority: exception, return, branch-exchange, mode write
	wire do_exc = exc_take;
	wire do_ret = !exc_take && exc_return && can_ret;
	wire do_bx  = !exc_take && !exc_return && branch_exchange_instr;
	wire do_mw  = !exc_take && !exc_return && !branch_exchange_instr &&
		mode_write && mode_ok(mode_wdata) && (mode != CSM_M_USR);

	// next status word
	logic [31:0] next_cpsr;
	always_comb
	begin
		next_cpsr = cpsr;
		if (do_exc)
		begin
			next_cpsr = {cpsr[31:8], 2'b11, 1'b0, exc_mode}; // RULE4 RULE10
		end
		else if (do_ret)
		begin
			next_cpsr = saved; // RULE2
		end
		else if (do_bx)
		begin
			next_cpsr[CSM_PSR_T] = bx_op[0]; // RULE1 RULE3 RULE5
		end
		else if (do_mw)
		begin
			next_cpsr[4:0] = mode_wdata; // RULE10
		end
	end

	// next program counter
	wire [31:0] pc_step = tbit ? 32'h0000_0002 : 32'h0000_0004;
	wire [31:0] next_pc = do_exc ? exc_vec :
		do_bx ? (bx_op[0] ? {bx_op[31:1], 1'b0} : {bx_op[31:2], 2'b00}) :
		pc_advance ? (pc_vis + pc_step) : pc;

	// status and pc registers
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cpsr <= CSM_RESET_PSR; // RULE4
			pc   <= CSM_RESET_PC;
		end
		else
		begin
			cpsr <= next_cpsr;
			pc   <= next_pc;
		end
	end

	// saved status written on exception entry
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 4; i++)
				spsr[i] <= CSM_RESET_PSR;
		end
		else if (do_exc)
		begin
			spsr[spsr_idx(exc_mode)] <= cpsr; // RULE2
		end
	end

	// state bit remembered per exception mode, kept apart from the saved status
	logic [3:0] ret_t_shadow;
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			ret_t_shadow <= 4'h0;
		else if (do_exc)
			ret_t_shadow[spsr_idx(exc_mode)] <= tbit;
	end
	wire shadow_t = ret_t_shadow[spsr_idx(mode)];

	// general register file; exception link write wins over a normal write
	generate
		for (genvar g = 0; g < NSLOT; g++)
		begin : g_rf
			always_ff @(posedge sys_clk or negedge arst_n)
			begin
				if (!arst_n)
					gpr[g] <= 32'h0;
				else if (do_exc && (lslot == 5'(g)))
					gpr[g] <= pc_vis; // RULE4
				else if (rf_we && (wslot == 5'(g)) && (rf_waddr != 4'(CSM_PC_IDX)))
					gpr[g] <= rf_wdata;
			end
		end
	endgenerate

	// read port
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			rf_rdata <= 32'h0;
		else
			rf_rdata <= (rf_raddr == 4'(CSM_PC_IDX)) ? pc_vis : gpr[rslot];
	end

	// fetch address and width follow the state
	assign fetch_addr = pc_vis; // RULE6
	assign fetch_size = tbit ? 2'(CSM_SZ_HALF) : 2'(CSM_SZ_WORD); // RULE6

	// data lanes
	wire [31:0] lane_rdata;
	csm_lane u_lane (
		.addr_lo   (mem_addr[1:0]),
		.size      (mem_size),
		.wdata     (mem_wdata),
		.bus_rdata (bus_rdata),
		.bus_wdata (bus_wdata),
		.byte_en   (bus_byte_en),
		.rdata     (lane_rdata)
	);

	// alignment check flags misplaced accesses
	wire mis = mem_req && (((mem_size == 2'(CSM_SZ_WORD)) && (mem_addr[1:0] != 2'b00)) ||
		((mem_size == 2'(CSM_SZ_HALF)) && mem_addr[0])); // RULE8
	assign mem_misaligned = mis;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			mem_rdata <= 32'h0;
		else if (mem_req)
			mem_rdata <= lane_rdata;
	end

	// outputs
	assign compact_state       = tbit;
	assign cur_mode            = mode;
	assign status_word         = cpsr;
	assign program_counter_reg = pc_vis;

	// checks
	bx_sets_state_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE1
		do_bx && bx_op[0] |=> compact_state)
		else $error("bx with bit0 set did not enter compact state");
	bx_clear_state_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE3
		do_bx && !bx_op[0] |=> !compact_state)
		else $error("bx with bit0 clear did not enter wide state");
	bx_keeps_mode_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE5
		do_bx |=> $stable(cur_mode))
		else $error("state change altered the mode");
	exc_wide_vec_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE4
		do_exc |=> !compact_state && (pc == $past(exc_vec)) && (cur_mode == $past(exc_mode)))
		else $error("exception entry wrong");
	ret_restore_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE2
		do_ret |=> compact_state == $past(shadow_t))
		else $error("exception return did not restore state");
	pc_align_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE13
		compact_state ? !program_counter_reg[0] : (program_counter_reg[1:0] == 2'b00))
		else $error("pc low bits not zero");
	fetch_size_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE6
		fetch_size == (compact_state ? 2'(CSM_SZ_HALF) : 2'(CSM_SZ_WORD)))
		else $error("fetch width does not follow state");
	legal_mode_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE9
		mode_ok(cur_mode))
		else $error("illegal mode");
	exc_priv_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE10
		do_exc |=> (cur_mode != CSM_M_USR) && (cur_mode != CSM_M_SYS))
		else $error("exception entered unprivileged mode");

	// pc stepping, link copy, mode locks and banking
	pc_step_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE6
		pc_advance && !exc_take && !exc_return && !branch_exchange_instr |=>
		program_counter_reg == $past(program_counter_reg) + ($past(compact_state) ? 32'h2 : 32'h4))
		else $error("pc advance step wrong");
	link_write_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE4
		do_exc |=> gpr[$past(lslot)] == $past(pc_vis))
		else $error("exception link not written");
	user_lock_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE10
		mode_write && (cur_mode == CSM_M_USR) && !exc_take |=> cur_mode == CSM_M_USR)
		else $error("user mode changed its own mode");
	mw_illegal_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE9
		mode_write && !mode_ok(mode_wdata) && !exc_take && !exc_return |=> $stable(cur_mode))
		else $error("illegal mode code accepted");
	fiq_bank_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE14
		(cur_mode == CSM_M_FIQ) && (rf_raddr >= 4'h8) && (rf_raddr <= 4'he) |->
		(rslot >= 5'h10) && (rslot <= 5'h16))
		else $error("fast irq register not banked");
	user_shared_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE11
		((cur_mode == CSM_M_USR) || (cur_mode == CSM_M_SYS)) |-> rslot == {1'b0, rf_raddr})
		else $error("user or system register banked");
	pc_read_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // RULE13
		(rf_raddr == 4'(CSM_PC_IDX)) |=> rf_rdata == $past(program_counter_reg))
		else $error("pc read value wrong");
endmodule
`default_nettype wire

// File: tb/csm_mem_model.sv
// read-only data memory model on the far side of the core's data bus
// assumes each byte holds its low address byte xor 5a
`timescale 1ns/1ps
`default_nettype none
module csm_mem_model
(
	// bus
	input  wire logic        sys_clk,
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	output logic      [31:0] bus_rdata
);
	logic [31:0] idle_pat = 32'h1234_abcd;
	logic [31:0] word;
	logic [5:0]  wa;
	// lowest address byte sits in the low lane
	assign wa = mem_addr[7:2];
	assign word = {wa, 2'h3, wa, 2'h2, wa, 2'h1, wa, 2'h0} ^ 32'h5a5a_5a5a;
	// unselected bus shows a moving pattern, never the last word
	always @(posedge sys_clk)
		idle_pat <= idle_pat * 32'h19 + 32'h3;
	assign bus_rdata = mem_req ? word : idle_pat;
endmodule
`default_nettype wire

// File: tb/csm_ctrl_tb_top.sv
// self-checking bench for the state and mode control block
// assumes the memory model sits on the data bus
`timescale 1ns/1ps
`default_nettype none
module csm_ctrl_tb_top
	import csm_pkg::*;
;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic bxi = 1'b0, exc_take = 1'b0, exc_return = 1'b0, mode_write = 1'b0, pc_advance = 1'b0;
	logic rf_we = 1'b0, mem_req = 1'b0;
	logic [3:0] bx_reg = '0, rf_waddr = '0, rf_raddr = '0, bus_byte_en;
	logic [2:0] exc_kind = '0;
	logic [4:0] mode_wdata = '0, cur_mode;
	logic [1:0] mem_size = '0, fetch_size;
	logic [31:0] rf_wdata = '0, mem_addr = '0, mem_wdata = '0, bus_rdata, rf_rdata;
	logic [31:0] mem_rdata, bus_wdata, status_word, fetch_addr, pc;
	logic mem_misaligned, compact_state;
	int mismatches = 0, cmp_count = 0, seed = 32'hee42, k;
	logic [31:0] r, v, op;
	logic [4:0] mt [5] = '{5'h13, 5'h1b, 5'h13, 5'h12, 5'h11};
	logic [31:0] vt [5] = '{CSM_VEC_RESET, CSM_VEC_UNDEFINED_INSTR_EXCEPTION, CSM_VEC_SWI, CSM_VEC_IRQ, CSM_VEC_FIQ};

	csm_ctrl i_csm_ctrl (.sys_clk(sys_clk), .arst_n(arst_n), .branch_exchange_instr(bxi),
		.bx_reg(bx_reg), .exc_take(exc_take), .exc_kind(exc_kind), .exc_return(exc_return),
		.mode_write(mode_write), .mode_wdata(mode_wdata), .pc_advance(pc_advance),
		.rf_we(rf_we), .rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .rf_raddr(rf_raddr),
		.rf_rdata(rf_rdata), .mem_req(mem_req), .mem_addr(mem_addr), .mem_size(mem_size),
		.mem_wdata(mem_wdata), .bus_rdata(bus_rdata), .mem_rdata(mem_rdata),
		.bus_wdata(bus_wdata), .bus_byte_en(bus_byte_en), .mem_misaligned(mem_misaligned),
		.compact_state(compact_state), .cur_mode(cur_mode), .status_word(status_word),
		.fetch_addr(fetch_addr), .fetch_size(fetch_size), .program_counter_reg(pc));
	csm_mem_model i_csm_mem_model (.sys_clk(sys_clk), .mem_req(mem_req),
		.mem_addr(mem_addr), .bus_rdata(bus_rdata));

	// clock
	always #12.5 sys_clk = ~sys_clk;

	// compare and count
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one control pulse: 0 bx, 1 exception, 2 return, 3 mode write, 4 advance, 5 reg write
	task ev(input int what, input int arg, input logic [31:0] wd);
		@(posedge sys_clk);
		bxi <= (what == 0);
		exc_take <= (what == 1);
		exc_return <= (what == 2);
		mode_write <= (what == 3);
		pc_advance <= (what == 4);
		rf_we <= (what == 5);
		bx_reg <= 4'(arg);
		exc_kind <= 3'(arg);
		mode_wdata <= 5'(arg);
		rf_waddr <= 4'(arg);
		rf_wdata <= wd;
		@(posedge sys_clk);
		{bxi, exc_take, exc_return, mode_write, pc_advance, rf_we} <= '0;
		#1;
	endtask

	// register read, data one edge after the address
	task rd(input int n, output logic [31:0] d);
		@(posedge sys_clk);
		rf_raddr <= 4'(n);
		repeat (2) @(posedge sys_clk);
		#1 d = rf_rdata;
	endtask

	// data access, byte of address a holds a xor 5a
	task acc(input int a, input int sz, input logic [31:0] er, input logic [3:0] be);
		@(posedge sys_clk);
		mem_req <= 1'b1;
		mem_addr <= 32'(a);
		mem_size <= 2'(sz);
		mem_wdata <= r;
		@(posedge sys_clk);
		#1;
		chk("misaligned", 32'(((sz == 1) && a[0]) || ((sz == 2) && (a[1:0] != 0))), 32'(mem_misaligned));
		if (be != 4'h0)
		begin
			chk("rdata", er, mem_rdata);
			chk("byte_en", 32'(be), 32'(bus_byte_en));
			chk("wlane", r[7:0], bus_wdata[8 * (a % 4) +: 8]);
		end
	endtask

	task conclude();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		#1;
		chk("reset psr", CSM_RESET_PSR, status_word);
		chk("reset pc", CSM_RESET_PC, pc);
		for (k = 0; k < 5; k++)
		begin
			r = $random(seed) | 32'h1;
			ev(5, 2, r);
			ev(0, 2, 0);
			chk("compact", 1, 32'(compact_state));
			chk("bx pc", r & ~32'h1, pc);
			chk("half fetch", 32'(CSM_SZ_HALF), 32'(fetch_size));
			ev(4, 0, 0);
			chk("adv2", (r & ~32'h1) + 2, fetch_addr);
			op = pc;
			ev(1, k, 0);
			chk("exc mode", 32'(mt[k]), 32'(cur_mode));
			chk("exc wide", 0, 32'(compact_state));
			chk("vector", vt[k], pc);
			chk("masked", 1, 32'(status_word[7]));
			rd(14, v);
			chk("link", op, v);
			if (k == 4)
			begin
				ev(5, 8, 32'h11);
				rd(8, v);
				chk("fiq r8", 32'h11, v);
			end
			ev(2, 0, 0);
			chk("ret compact", 1, 32'(compact_state));
			chk("ret mode", 32'h13, 32'(cur_mode));
			rd(2, v);
			chk("r2 kept", r, v);
		end
		rd(8, v);
		chk("r8 unbanked", 0, v);
		r = ($random(seed) & ~32'h1) | 32'h2;
		ev(5, 3, r);
		ev(0, 3, 0);
		chk("wide", 0, 32'(compact_state));
		chk("word pc", r & ~32'h3, pc);
		chk("word fetch", 32'(CSM_SZ_WORD), 32'(fetch_size));
		ev(4, 0, 0);
		chk("adv4", (r & ~32'h3) + 4, pc);
		ev(3, 5'h1f, 0);
		chk("sys", 32'h1f, 32'(cur_mode));
		ev(3, 5'h17, 0);
		chk("no abort", 32'h1f, 32'(cur_mode));
		ev(3, 5'h10, 0);
		ev(3, 5'h13, 0);
		chk("user locked", 32'h10, 32'(cur_mode));
		ev(2, 0, 0);
		chk("user ret", 32'h10, 32'(cur_mode));
		ev(1, 3, 0);
		ev(2, 0, 0);
		chk("back user", 32'h10, 32'(cur_mode));
		r = $random(seed);
		for (k = 0; k < 4; k++)
			acc(32'h40 + k, 0, 32'((32'h40 + k) ^ 32'h5a), 4'h1 << k);
		acc(32'h42, 1, 32'h1918, 4'hc);
		acc(32'h40, 2, 32'h1918_1b1a, 4'hf);
		acc(32'h41, 1, 0, 4'h0);
		acc(32'h42, 2, 0, 4'h0);
		@(posedge sys_clk);
		mem_req <= 1'b0;
		conclude();
	end
endmodule
`default_nettype wire
